// >>> inc/loop_hold_pkg.sv
// Behaviour
// - balance window enable freezes balance loop when feedback leaves ref-25mV..ref+20mV
// - balance period enable freezes balance loop on excess pwm period error
// - balance phase enable freezes balance loop whenever active phase count changes
// - balance transition enable freezes balance loop during dynamic voltage change
// - balance hold time is a 4-bit field, 100 us per count
// - top bit of frequency control ignores writes and reads zero
// - frequency window enable freezes frequency loop when feedback leaves window
// - frequency phase enable freezes frequency loop when phase count changes
// - frequency transition enable freezes frequency loop during dynamic voltage change
// - frequency hold time is a 4-bit field, 100 us per count
// - frequency loop runs only while its enable bit is one
// - 7-bit unsigned field is the frequency loop integral gain
// - period error compared at 80 ns per threshold count, both directions
`default_nettype none
package loop_hold_pkg;
    localparam logic [7:0] CMD_CB_CTRL = 8'h31;
    localparam logic [7:0] CMD_FS_CTRL = 8'h32;
    localparam logic [7:0] CB_RESET = 8'h00;
    localparam logic [15:0] FS_RESET = 16'h0000;
    localparam int CB_WIN_EN_BIT = 7;
    localparam int CB_PRD_EN_BIT = 6;
    localparam int CB_PHASE_EN_BIT = 5;
    localparam int CB_DVC_EN_BIT = 4;
    localparam int CB_DUR_LSB = 0;
    localparam int FS_RSVD_BIT = 15;
    localparam int FS_WIN_EN_BIT = 14;
    localparam int FS_PHASE_EN_BIT = 13;
    localparam int FS_DVC_EN_BIT = 12;
    localparam int FS_DUR_LSB = 8;
    localparam int FREQ_LOOP_ENABLE_BIT = 7;
    localparam int FS_GAIN_LSB = 0;
    localparam int DUR_W = 4;
    localparam int GAIN_W = 7;
    localparam logic [15:0] FS_WRITE_MASK = 16'h7fff;
    // feedback and reference are in 1 mV counts
    localparam int VOLT_W = 12;
    localparam logic [13:0] WIN_LOW_MV = 14'h0019;
    localparam logic [13:0] WIN_HIGH_MV = 14'h0014;
    localparam int PHASE_W = 3;
    localparam int PERIOD_W = 16;
    localparam int THR_W = 7;
    localparam int CLK_PERIOD_NS = 25;
    localparam int THR_LSB_NS = 80;
    localparam int HOLD_LSB_US = 100;
    localparam int HOLD_LSB_CYCLES = (HOLD_LSB_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
endpackage
`default_nettype wire

// >>> hw/loop_hold_control.sv
`default_nettype none
module loop_hold_control #(
    parameter int HOLD_UNIT_CYCLES = loop_hold_pkg::HOLD_LSB_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic wr_en_i,
    input wire logic [15:0] wr_data_i,
    input wire logic rd_en_i,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic [loop_hold_pkg::VOLT_W-1:0] feedback_voltage_i,
    input wire logic [loop_hold_pkg::VOLT_W-1:0] output_reference_i,
    input wire logic [loop_hold_pkg::PERIOD_W-1:0] measured_period_i,
    input wire logic [loop_hold_pkg::PERIOD_W-1:0] configured_period_i,
    input wire logic [loop_hold_pkg::THR_W-1:0] period_error_threshold_i,
    input wire logic [loop_hold_pkg::PHASE_W-1:0] phase_count_i,
    input wire logic dynamic_voltage_change_i,
    output logic current_balance_hold_o,
    output logic current_balance_update_o,
    output logic freq_hold_o,
    output logic freq_loop_run_o,
    output logic [loop_hold_pkg::GAIN_W-1:0] freq_integral_gain_o
);
    localparam logic [loop_hold_pkg::CNT_W-1:0] UNIT =
        loop_hold_pkg::CNT_W'(HOLD_UNIT_CYCLES);

    logic [7:0] cb_ctrl_reg;
    logic [15:0] fs_ctrl_reg;
    logic [loop_hold_pkg::PHASE_W-1:0] phase_prev_reg;
    logic [loop_hold_pkg::CNT_W-1:0] cb_cnt_reg;
    logic [loop_hold_pkg::CNT_W-1:0] cb_cnt_next;
    logic [loop_hold_pkg::CNT_W-1:0] fs_cnt_reg;
    logic [loop_hold_pkg::CNT_W-1:0] fs_cnt_next;
    logic cb_hold_reg;
    logic fs_hold_reg;
    logic [15:0] rd_data_reg;
    logic rd_valid_reg;

    function automatic logic out_of_window(
        input logic [loop_hold_pkg::VOLT_W-1:0] fb,
        input logic [loop_hold_pkg::VOLT_W-1:0] vref
    );
        logic signed [13:0] diff;
        diff = signed'({2'b00, fb}) - signed'({2'b00, vref});
        return (diff < -signed'(loop_hold_pkg::WIN_LOW_MV))
            || (diff > signed'(loop_hold_pkg::WIN_HIGH_MV));
    endfunction

    function automatic logic period_error(
        input logic [loop_hold_pkg::PERIOD_W-1:0] meas,
        input logic [loop_hold_pkg::PERIOD_W-1:0] cfg,
        input logic [loop_hold_pkg::THR_W-1:0] thr
    );
        logic [loop_hold_pkg::PERIOD_W-1:0] dev;
        logic [23:0] dev_ns;
        logic [23:0] thr_ns;
        dev = (meas > cfg) ? meas - cfg : cfg - meas;
        dev_ns = 24'(dev) * 24'(loop_hold_pkg::CLK_PERIOD_NS);
        thr_ns = 24'(thr) * 24'(loop_hold_pkg::THR_LSB_NS);
        return dev_ns > thr_ns;
    endfunction

    // a live trigger reloads the full hold; otherwise count down to zero
    function automatic logic [loop_hold_pkg::CNT_W-1:0] next_count(
        input logic trig,
        input logic [loop_hold_pkg::DUR_W-1:0] dur,
        input logic [loop_hold_pkg::CNT_W-1:0] cnt
    );
        logic [loop_hold_pkg::CNT_W-1:0] load;
        load = loop_hold_pkg::CNT_W'(loop_hold_pkg::CNT_W'(dur) * UNIT);
        if (trig) begin
            return load;
        end
        return (cnt != '0) ? cnt - 1'b1 : cnt;
    endfunction

    wire sel_cb = cmd_code_i == loop_hold_pkg::CMD_CB_CTRL;
    wire sel_fs = cmd_code_i == loop_hold_pkg::CMD_FS_CTRL;
    wire win_out = out_of_window(feedback_voltage_i, output_reference_i);
    wire prd_err = period_error(measured_period_i, configured_period_i,
        period_error_threshold_i);
    wire phase_chg = phase_count_i != phase_prev_reg;

    wire [loop_hold_pkg::DUR_W-1:0] cb_dur =
        cb_ctrl_reg[loop_hold_pkg::CB_DUR_LSB +: loop_hold_pkg::DUR_W];
    wire [loop_hold_pkg::DUR_W-1:0] fs_dur =
        fs_ctrl_reg[loop_hold_pkg::FS_DUR_LSB +: loop_hold_pkg::DUR_W];

    wire cb_trig_win = cb_ctrl_reg[loop_hold_pkg::CB_WIN_EN_BIT] & win_out;
    wire cb_trig_prd = cb_ctrl_reg[loop_hold_pkg::CB_PRD_EN_BIT] & prd_err;
    wire cb_trig_ph = cb_ctrl_reg[loop_hold_pkg::CB_PHASE_EN_BIT] & phase_chg;
    wire cb_trig_dvc = cb_ctrl_reg[loop_hold_pkg::CB_DVC_EN_BIT] & dynamic_voltage_change_i;
    wire cb_trig = cb_trig_win | cb_trig_prd | cb_trig_ph | cb_trig_dvc;

    wire fs_trig_win = fs_ctrl_reg[loop_hold_pkg::FS_WIN_EN_BIT] & win_out;
    wire fs_trig_ph = fs_ctrl_reg[loop_hold_pkg::FS_PHASE_EN_BIT] & phase_chg;
    wire fs_trig_dvc = fs_ctrl_reg[loop_hold_pkg::FS_DVC_EN_BIT] & dynamic_voltage_change_i;
    wire fs_trig = fs_trig_win | fs_trig_ph | fs_trig_dvc;

    assign cb_cnt_next = next_count(cb_trig, cb_dur, cb_cnt_reg);
    assign fs_cnt_next = next_count(fs_trig, fs_dur, fs_cnt_reg);

    wire [15:0] fs_wr_value = wr_data_i & loop_hold_pkg::FS_WRITE_MASK;
    wire [15:0] rd_mux = sel_cb ? {8'h00, cb_ctrl_reg} :
        (sel_fs ? fs_ctrl_reg : 16'h0000);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cb_ctrl_reg <= loop_hold_pkg::CB_RESET;
            fs_ctrl_reg <= loop_hold_pkg::FS_RESET;
        end else if (wr_en_i) begin
            if (sel_cb) begin
                cb_ctrl_reg <= wr_data_i[7:0];
            end
            if (sel_fs) begin
                fs_ctrl_reg <= fs_wr_value;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_en_i;
            if (rd_en_i) begin
                rd_data_reg <= rd_mux;
            end
        end
    end

    // timers restart on any live trigger
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_prev_reg <= '0;
            cb_cnt_reg <= '0;
            fs_cnt_reg <= '0;
            cb_hold_reg <= 1'b0;
            fs_hold_reg <= 1'b0;
        end else begin
            phase_prev_reg <= phase_count_i;
            cb_cnt_reg <= cb_cnt_next;
            fs_cnt_reg <= fs_cnt_next;
            cb_hold_reg <= cb_trig | (cb_cnt_next != '0);
            fs_hold_reg <= fs_trig | (fs_cnt_next != '0);
        end
    end

    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;
    assign current_balance_hold_o = cb_hold_reg;
    assign freq_hold_o = fs_hold_reg;
    assign current_balance_update_o = ~cb_hold_reg;
    assign freq_loop_run_o = fs_ctrl_reg[loop_hold_pkg::FREQ_LOOP_ENABLE_BIT] & ~fs_hold_reg;
    assign freq_integral_gain_o =
        fs_ctrl_reg[loop_hold_pkg::FS_GAIN_LSB +: loop_hold_pkg::GAIN_W];

    // cycles since the last trigger; a control write clears it, since a
    // duration changed mid-hold only takes effect at the next trigger
    function automatic logic [loop_hold_pkg::CNT_W-1:0] age_step(
        input logic trig,
        input logic clr,
        input logic [loop_hold_pkg::CNT_W-1:0] age
    );
        if (clr) begin
            return '0;
        end
        if (trig) begin
            return loop_hold_pkg::CNT_W'(1);
        end
        return (age == '0 || age == '1) ? age : age + 1'b1;
    endfunction

    // a zero duration still holds for the trigger cycle itself
    function automatic logic [loop_hold_pkg::CNT_W-1:0] hold_span(
        input logic [loop_hold_pkg::DUR_W-1:0] dur
    );
        logic [loop_hold_pkg::CNT_W-1:0] span;
        span = UNIT * loop_hold_pkg::CNT_W'(dur);
        return (span == '0) ? loop_hold_pkg::CNT_W'(1) : span;
    endfunction

    logic [loop_hold_pkg::CNT_W-1:0] cb_age_reg;
    logic [loop_hold_pkg::CNT_W-1:0] fs_age_reg;
    wire [loop_hold_pkg::CNT_W-1:0] cb_span = hold_span(cb_dur);
    wire [loop_hold_pkg::CNT_W-1:0] fs_span = hold_span(fs_dur);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cb_age_reg <= '0;
            fs_age_reg <= '0;
        end else begin
            cb_age_reg <= age_step(cb_trig, wr_en_i & sel_cb, cb_age_reg);
            fs_age_reg <= age_step(fs_trig, wr_en_i & sel_fs, fs_age_reg);
        end
    end

    default clocking cb_clk @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    cb_win_hold_a: assert property (
        cb_ctrl_reg[loop_hold_pkg::CB_WIN_EN_BIT] && win_out |=> current_balance_hold_o)
        else $error("balance loop not held on window exit");

    win_low_edge_a: assert property (
        14'(feedback_voltage_i) + loop_hold_pkg::WIN_LOW_MV == 14'(output_reference_i)
        |-> !win_out)
        else $error("window exit flagged at the lower limit");

    cb_prd_hold_a: assert property (
        cb_ctrl_reg[loop_hold_pkg::CB_PRD_EN_BIT] && prd_err |=> current_balance_hold_o)
        else $error("balance loop not held on period error");

    cb_phase_hold_a: assert property (
        cb_ctrl_reg[loop_hold_pkg::CB_PHASE_EN_BIT] && phase_count_i != phase_prev_reg
        |=> current_balance_hold_o)
        else $error("balance loop not held on phase change");

    cb_dvc_hold_a: assert property (
        cb_ctrl_reg[loop_hold_pkg::CB_DVC_EN_BIT] && dynamic_voltage_change_i
        |=> current_balance_hold_o)
        else $error("balance loop not held during transition");

    cb_hold_len_a: assert property (
        cb_trig && cb_dur == 4'h2 ##1 !cb_trig [*2]
        |-> cb_cnt_reg == UNIT + UNIT - 16'h0001)
        else $error("balance hold count wrong");

    cb_span_a: assert property (
        cb_age_reg != '0 |-> current_balance_hold_o == (cb_age_reg <= cb_span))
        else $error("balance hold length differs from its field");

    fs_rsvd_zero_a: assert property (
        rd_valid_o && $past(sel_fs) |-> !rd_data_o[loop_hold_pkg::FS_RSVD_BIT])
        else $error("reserved frequency bit read as one");

    fs_rsvd_wr_a: assert property (
        wr_en_i && sel_fs |=> !fs_ctrl_reg[loop_hold_pkg::FS_RSVD_BIT])
        else $error("reserved frequency bit stored on write");

    fs_win_hold_a: assert property (
        fs_ctrl_reg[loop_hold_pkg::FS_WIN_EN_BIT] && win_out |=> freq_hold_o && !freq_loop_run_o)
        else $error("frequency loop not held on window exit");

    win_high_edge_a: assert property (
        14'(feedback_voltage_i) == 14'(output_reference_i) + loop_hold_pkg::WIN_HIGH_MV
        |-> !win_out)
        else $error("window exit flagged at the upper limit");

    fs_phase_hold_a: assert property (
        fs_ctrl_reg[loop_hold_pkg::FS_PHASE_EN_BIT] && phase_count_i != phase_prev_reg
        |=> freq_hold_o)
        else $error("frequency loop not held on phase change");

    fs_dvc_hold_a: assert property (
        fs_ctrl_reg[loop_hold_pkg::FS_DVC_EN_BIT] && dynamic_voltage_change_i |=> freq_hold_o)
        else $error("frequency loop not held during transition");

    fs_hold_end_a: assert property (
        fs_trig && fs_dur == 4'h0 ##1 !fs_trig |=> !freq_hold_o)
        else $error("frequency zero hold did not release");

    fs_span_a: assert property (
        fs_age_reg != '0 |-> freq_hold_o == (fs_age_reg <= fs_span))
        else $error("frequency hold length differs from its field");

    fs_run_gate_a: assert property (
        wr_en_i && sel_fs && !wr_data_i[loop_hold_pkg::FREQ_LOOP_ENABLE_BIT] |=> !freq_loop_run_o)
        else $error("frequency loop runs after being disabled");

    fs_run_on_a: assert property (
        wr_en_i && sel_fs && wr_data_i[loop_hold_pkg::FREQ_LOOP_ENABLE_BIT] && !fs_trig
        && fs_cnt_reg <= 16'h0001 |=> freq_loop_run_o)
        else $error("enabled frequency loop does not run");

    fs_gain_wr_a: assert property (
        wr_en_i && sel_fs |=> freq_integral_gain_o == $past(wr_data_i[6:0]))
        else $error("integral gain not taken from write");

    prd_scale_a: assert property (
        measured_period_i == configured_period_i + 16'h0011 && period_error_threshold_i == 7'h05
        |-> prd_err)
        else $error("period error scale wrong");

    prd_floor_a: assert property (
        17'(measured_period_i) == 17'(configured_period_i) + 17'h00010
        && period_error_threshold_i == 7'h05 |-> !prd_err)
        else $error("period error flagged at the threshold");

    prd_neg_a: assert property (
        configured_period_i == measured_period_i + 16'h0011 && period_error_threshold_i == 7'h05
        |-> prd_err)
        else $error("short period error missed");

    cb_frozen_a: assert property (
        cb_trig |=> current_balance_hold_o && !current_balance_update_o)
        else $error("balance loop updated while held");

    cb_resume_a: assert property (
        !cb_trig && cb_cnt_reg <= 16'h0001 |=> current_balance_update_o)
        else $error("balance loop not resumed after hold expiry");

    fs_resume_a: assert property (
        !fs_trig && fs_cnt_reg <= 16'h0001 |=> !freq_hold_o)
        else $error("frequency loop not resumed after hold expiry");
endmodule
`default_nettype wire

// >>> tb/tb_loop_hold_control.sv
`default_nettype none
module tb_loop_hold_control;
    timeunit 1ns;
    timeprecision 1ps;
    // short hold unit keeps every hold window inside a 60-cycle measurement
    localparam int UNIT = 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] cmd = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [15:0] wdat = 16'h0000;
    logic [15:0] rdat;
    logic rvld, cb_hold, cb_upd, fs_hold, fs_run;
    logic [6:0] gain;
    logic [11:0] fb = 12'h3e8;
    logic [11:0] vref = 12'h3e8;
    logic [15:0] meas = 16'h03e8;
    logic [15:0] cfg = 16'h03e8;
    logic [6:0] thr = 7'h05;
    logic [2:0] phase = 3'h0;
    logic dvc = 1'b0;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] cben [6] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h20, 8'h10};
    logic [15:0] fsen [6] = '{16'h4000, 16'h4000, 16'h0000, 16'h0000, 16'h2000, 16'h1000};
    int fse [6] = '{12, 12, 0, 0, 12, 12};

    loop_hold_control #(.HOLD_UNIT_CYCLES(UNIT)) loop_hold_control_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cmd_code_i(cmd), .wr_en_i(wr_en), .wr_data_i(wdat),
        .rd_en_i(rd_en), .rd_data_o(rdat), .rd_valid_o(rvld), .feedback_voltage_i(fb),
        .output_reference_i(vref), .measured_period_i(meas), .configured_period_i(cfg),
        .period_error_threshold_i(thr), .phase_count_i(phase), .dynamic_voltage_change_i(dvc),
        .current_balance_hold_o(cb_hold), .current_balance_update_o(cb_upd),
        .freq_hold_o(fs_hold), .freq_loop_run_o(fs_run), .freq_integral_gain_o(gain)
    );

    initial begin
        forever #12.5ns clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkn(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // leading edge wait keeps strobes from being set twice in one step
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk_i);
        cmd = c;
        wdat = d;
        wr_en = 1'b1;
        @(negedge clk_i);
        wr_en = 1'b0;
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        @(negedge clk_i);
        cmd = c;
        rd_en = 1'b1;
        @(negedge clk_i);
        rd_en = 1'b0;
        chk({15'h0000, rvld}, 16'h0001);
        chk(rdat, e);
    endtask

    // trigger held w cycles; held and stopped cycles counted over 60 cycles from trigger onset
    task automatic trig(input int k, input int w, input int ecb, input int efs);
        int ncb;
        int nfs;
        int nup;
        int nru;
        ncb = 0;
        nfs = 0;
        nup = 0;
        nru = 0;
        case (k)
            0: fb = 12'h3ce;
            1: fb = 12'h3fd;
            2: meas = 16'h03f9;
            3: meas = 16'h03d7;
            4: phase = phase + 3'h1;
            5: dvc = 1'b1;
            6: fb = 12'h3cf;
            7: fb = 12'h3fc;
            8: meas = 16'h03f8;
            9: meas = 16'h03d8;
            default: ;
        endcase
        for (int i = 0; i < 60; i++) begin
            @(negedge clk_i);
            ncb += (cb_hold === 1'b1);
            nfs += (fs_hold === 1'b1);
            nup += (cb_upd === 1'b0);
            nru += (fs_run === 1'b0);
            if (i == w - 1) begin
                fb = 12'h3e8;
                meas = 16'h03e8;
                dvc = 1'b0;
            end
        end
        chkn(ncb, ecb);
        chkn(nfs, efs);
        chkn(nup, ecb);
        chkn(nru, efs);
    endtask

    initial begin
        repeat (4) @(negedge clk_i);
        chk({12'h000, cb_hold, cb_upd, fs_hold, fs_run}, 16'h0004);
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        rd(8'h31, 16'h0000);
        rd(8'h32, 16'h0000);
        wr(8'h32, 16'hffff);
        chk({9'h000, gain}, 16'h007f);
        rd(8'h32, 16'h7fff);
        wr(8'h31, 16'hffff);
        rd(8'h31, 16'h00ff);
        rd(8'h33, 16'h0000);
        wr(8'h32, 16'h0000);
        chk({15'h0000, fs_run}, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            wr(8'h31, {8'h00, cben[k] | 8'h02});
            wr(8'h32, fsen[k] | 16'h03aa);
            trig(k, 1, 8, fse[k]);
        end
        chk({9'h000, gain}, 16'h002a);
        wr(8'h31, 16'h000f);
        wr(8'h32, 16'h0faa);
        for (int k = 0; k < 6; k++)
            trig(k, 1, 0, 0);
        wr(8'h31, 16'h00f2);
        wr(8'h32, 16'h73aa);
        for (int k = 6; k < 10; k++)
            trig(k, 1, 0, 0);
        trig(2, 1, 8, 0);
        trig(5, 4, 11, 15);
        wr(8'h31, 16'h0010);
        wr(8'h32, 16'h1080);
        trig(5, 1, 1, 1);
        wrap_up();
    end
endmodule
`default_nettype wire
